// ===== inc/ipp_pkg.sv
// Constants, register map and carrier types of the image post-processing unit.
package ipp_pkg;

  localparam logic [31:0] BASE_ADDR    = 32'h1308_0000;
  localparam logic [7:0]  OFF_CONTROL  = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_FORMAT   = 8'h08;
  localparam logic [7:0]  OFF_Y_ADDR   = 8'h0c;
  localparam logic [7:0]  OFF_U_ADDR   = 8'h10;
  localparam logic [7:0]  OFF_V_ADDR   = 8'h14;
  localparam logic [7:0]  OFF_D_ADDR   = 8'h18;
  localparam logic [7:0]  OFF_IN_SIZE  = 8'h1c;
  localparam logic [7:0]  OFF_OUT_SIZE = 8'h20;
  localparam logic [7:0]  OFF_LUT_PORT = 8'h24;

  localparam int CB_ENABLE = 0;
  localparam int CB_RUN = 1;
  localparam int CB_HRSZ = 2;
  localparam int CB_VRSZ = 3;
  localparam int CB_CSC = 4;
  localparam int CB_IRQ_EN = 5;
  localparam int CB_SRST = 6;
  localparam int CB_H_UP = 8;
  localparam int CB_V_UP = 9;
  localparam int CB_PACKED = 10;
  localparam int CB_TO_DISP = 11;
  localparam int CB_SRC_PMAP = 12;
  localparam int CB_DST_PMAP = 13;
  localparam int CB_FIELD_MODE = 14;
  localparam int CB_FIELD_LOAD = 15;
  localparam int CB_FIELD_SEL = 16;
  localparam int CB_FIXED_DST = 17;
  localparam int CTRL_W = 18;
  localparam logic [17:0] CTRL_RW_MASK = 18'h3_7f3f;
  localparam logic [17:0] CTRL_RESET   = 18'h0_0000;

  localparam int SB_OUT_END = 0;
  localparam int SB_FORMAT_ERROR_FLAG = 1;
  localparam int SB_SIZE_ERR = 2;
  localparam logic OUT_END_RESET = 1'b1;

  localparam int FB_IN_FMT = 0;
  localparam int FB_OUT_FMT = 19;
  localparam int SZ_W_LSB = 0;
  localparam int SZ_H_LSB = 16;
  localparam int LUT_SEL_BIT = 31;
  localparam int LUT_IDX_LSB = 16;

  localparam logic [1:0] IN_420 = 2'h0;
  localparam logic [1:0] IN_422 = 2'h1;
  localparam logic [1:0] IN_444 = 2'h2;
  localparam logic [1:0] IN_411 = 2'h3;
  localparam logic [1:0] OUT_RGB555 = 2'h0;
  localparam logic [1:0] OUT_RGB565 = 2'h1;
  localparam logic [1:0] OUT_RGB888 = 2'h2;
  localparam logic [1:0] OUT_YUV422 = 2'h3;

  localparam int DIM_W = 12;
  localparam logic [11:0] MIN_DIM = 12'h002;
  localparam logic [11:0] MAX_OUT_W_VRSZ = 12'h320;
  localparam int LUT_DEPTH = 32;
  localparam int STEP_W = 11;
  localparam logic [10:0] STEP_UNIT = 11'h020;
  localparam logic [10:0] STEP_UP_MIN = 11'h010;
  localparam logic [10:0] STEP_DN_MAX = 11'h400;
  localparam int POS_W = 23;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        page_map;
  } ipp_rd_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [31:0] data;
    logic        page_map;
  } ipp_wr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } ipp_disp_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ipp_bus_t;

endpackage

// ===== rtl/ipp_color_convert.sv
// Pixel colour conversion and packing into one output word.
`timescale 1ns/100ps
`default_nettype none
module ipp_color_convert #(
  parameter int COEF_RV = 359,
  parameter int COEF_GU = 88,
  parameter int COEF_GV = 183,
  parameter int COEF_BU = 454
) (
  input  wire logic [7:0]  luma,
  input  wire logic [7:0]  cb,
  input  wire logic [7:0]  cr,
  input  wire logic        color_convert_enable,
  input  wire logic [1:0]  out_fmt,
  input  wire logic        odd_pixel,
  output logic      [31:0] pixel_word
);

  function automatic logic [7:0] ipp_clamp(input int v);
    if (v < 0) begin
      return 8'h00;
    end
    if (v > 255) begin
      return 8'hff;
    end
    return v[7:0];
  endfunction

  always_comb begin
    int   du;
    int   dv;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r  = 8'h00;
    g  = 8'h00;
    b  = 8'h00;
    du = int'(cb) - 128;
    dv = int'(cr) - 128;
    if (color_convert_enable) begin
      r = ipp_clamp(int'(luma) + ((COEF_RV * dv) >>> 8));
      g = ipp_clamp(int'(luma) - ((COEF_GU * du + COEF_GV * dv) >>> 8));
      b = ipp_clamp(int'(luma) + ((COEF_BU * du) >>> 8));
    end else begin
      r = luma;
      g = cb;
      b = cr;
    end
    unique case (out_fmt)
      ipp_pkg::OUT_RGB555: pixel_word = {17'h0_0000, r[7:3], g[7:3], b[7:3]};
      ipp_pkg::OUT_RGB565: pixel_word = {16'h0000, r[7:3], g[7:2], b[7:3]};
      ipp_pkg::OUT_RGB888: pixel_word = {8'h00, r, g, b};
      ipp_pkg::OUT_YUV422: pixel_word = {16'h0000, (odd_pixel ? cr : cb), luma};
    endcase
  end

endmodule
`default_nettype wire

// ===== rtl/ipp_unit.sv
// Image post-processing unit: registers, frame fetch engine, resize stepping and output.
`timescale 1ns/100ps
`default_nettype none
module ipp_unit #(
  parameter int LUT_DEPTH = ipp_pkg::LUT_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire ipp_pkg::ipp_bus_t reg_bus,
  output logic      [31:0]       reg_rdata,
  output ipp_pkg::ipp_rd_t       mem_rd,
  input  wire logic              mem_rd_ack,
  input  wire logic [31:0]       mem_rd_data,
  output ipp_pkg::ipp_wr_t       mem_wr,
  input  wire logic              mem_wr_ack,
  output ipp_pkg::ipp_disp_t     disp_out,
  input  wire logic              disp_ready,
  input  wire logic              disp_req,
  output logic                   irq_n
);

  typedef enum logic [2:0] {
    IPP_IDLE, IPP_NEXT, IPP_RD_Y, IPP_RD_U, IPP_RD_V, IPP_EMIT, IPP_WAIT_OUT, IPP_HOLD
  } ipp_phase_t;

  typedef struct packed {
    logic [17:0]               ctrl;
    logic                      out_end;
    logic                      format_error_flag;
    logic                      size_err;
    logic [1:0]                in_fmt;
    logic [1:0]                out_fmt;
    logic [31:0]               y_addr;
    logic [31:0]               u_addr;
    logic [31:0]               v_addr;
    logic [31:0]               d_addr;
    logic [11:0]               in_w;
    logic [11:0]               in_h;
    logic [11:0]               out_w;
    logic [11:0]               out_h;
    logic                      field;
    ipp_phase_t                phase;
    logic [11:0]               col;
    logic [11:0]               row;
    logic [ipp_pkg::POS_W-1:0] hpos;
    logic [ipp_pkg::POS_W-1:0] vpos;
    logic                      last;
    logic [7:0]                yb;
    logic [7:0]                ub;
    logic [7:0]                vb;
    logic [31:0]               wptr;
    ipp_pkg::ipp_rd_t          rd;
    ipp_pkg::ipp_wr_t          wr;
    ipp_pkg::ipp_disp_t        disp;
    logic [31:0]               rdata;
    logic                      irq_n;
  } ipp_state_t;

  localparam ipp_state_t STATE_RESET = '{
    ctrl: ipp_pkg::CTRL_RESET, out_end: ipp_pkg::OUT_END_RESET, phase: IPP_IDLE, irq_n: 1'b1, default: '0
  };

  ipp_state_t s_reg;
  ipp_state_t s_next;
  logic [ipp_pkg::STEP_W-1:0] hlut [LUT_DEPTH];
  logic [ipp_pkg::STEP_W-1:0] vlut [LUT_DEPTH];
  logic [31:0] pix_word;

  // Tables are memories: software preloads them and the soft reset leaves them alone.
  always_ff @(posedge sys_clk) begin
    if (reg_bus.sel && reg_bus.wr && reg_bus.addr == ipp_pkg::OFF_LUT_PORT) begin
      if (reg_bus.wdata[ipp_pkg::LUT_SEL_BIT]) begin
        vlut[reg_bus.wdata[ipp_pkg::LUT_IDX_LSB +: 5]] <= reg_bus.wdata[ipp_pkg::STEP_W-1:0];
      end else begin
        hlut[reg_bus.wdata[ipp_pkg::LUT_IDX_LSB +: 5]] <= reg_bus.wdata[ipp_pkg::STEP_W-1:0];
      end
    end
  end

  // Keeps a table step inside the legal range for the chosen direction.
  function automatic logic [ipp_pkg::STEP_W-1:0] ipp_step(input logic [ipp_pkg::STEP_W-1:0] raw,
                                                         input logic en, input logic up);
    if (!en) begin
      return ipp_pkg::STEP_UNIT;
    end
    if (up) begin
      if (raw < ipp_pkg::STEP_UP_MIN) begin
        return ipp_pkg::STEP_UP_MIN;
      end
      return (raw > ipp_pkg::STEP_UNIT) ? ipp_pkg::STEP_UNIT : raw;
    end
    if (raw < ipp_pkg::STEP_UNIT) begin
      return ipp_pkg::STEP_UNIT;
    end
    return (raw > ipp_pkg::STEP_DN_MAX) ? ipp_pkg::STEP_DN_MAX : raw;
  endfunction

  // Source coordinate of a position, held inside the source image.
  function automatic logic [11:0] ipp_src(input logic [ipp_pkg::POS_W-1:0] pos, input logic [11:0] lim);
    logic [ipp_pkg::POS_W-6:0] whole;
    whole = pos[ipp_pkg::POS_W-1:5];
    return (whole >= {6'h00, lim}) ? lim - 12'h001 : whole[11:0];
  endfunction

  // Byte offset of a chroma sample for each planar sampling.
  function automatic logic [31:0] ipp_chroma_off(input logic [1:0] fmt, input logic [11:0] x,
                                                 input logic [11:0] y, input logic [11:0] w);
    unique case (fmt)
      ipp_pkg::IN_420: return ({20'h0_0000, y >> 1} * {20'h0_0000, w >> 1}) + {20'h0_0000, x >> 1};
      ipp_pkg::IN_422: return ({20'h0_0000, y} * {20'h0_0000, w >> 1}) + {20'h0_0000, x >> 1};
      ipp_pkg::IN_444: return ({20'h0_0000, y} * {20'h0_0000, w}) + {20'h0_0000, x};
      ipp_pkg::IN_411: return ({20'h0_0000, y} * {20'h0_0000, w >> 2}) + {20'h0_0000, x >> 2};
    endcase
  endfunction

  function automatic logic [7:0] ipp_lane(input logic [31:0] word, input logic [1:0] lane);
    return word[{lane, 3'h0} +: 8];
  endfunction

  ipp_color_convert u_convert (
    .luma       (s_reg.yb),
    .cb         (s_reg.ub),
    .cr         (s_reg.vb),
    .color_convert_enable     (s_reg.ctrl[ipp_pkg::CB_CSC]),
    .out_fmt    (s_reg.out_fmt),
    .odd_pixel  (s_reg.col[0]),
    .pixel_word (pix_word)
  );

  always_comb begin
    logic [11:0] sx;
    logic [11:0] sy;
    logic [31:0] packed_off;
    logic        wr_ctrl;
    logic        rd_status;
    logic        start;
    logic        done;
    logic [17:0] wctl;
    s_next     = s_reg;
    sx         = ipp_src(s_reg.hpos, s_reg.in_w);
    sy         = ipp_src(s_reg.vpos, s_reg.in_h);
    packed_off = ({20'h0_0000, sy} * {20'h0_0000, s_reg.in_w} + {20'h0_0000, sx[11:1], 1'b0}) << 1;
    wr_ctrl    = reg_bus.sel && reg_bus.wr && reg_bus.addr == ipp_pkg::OFF_CONTROL;
    rd_status  = reg_bus.sel && reg_bus.rd && reg_bus.addr == ipp_pkg::OFF_STATUS;
    wctl       = reg_bus.wdata[ipp_pkg::CTRL_W-1:0];
    start      = 1'b0;
    done       = 1'b0;

    if (reg_bus.sel && reg_bus.rd) begin
      unique case (reg_bus.addr)
        // offsets from base, reserved and trigger bits read zero
        ipp_pkg::OFF_CONTROL:  s_next.rdata = {14'h0000, s_reg.ctrl & ipp_pkg::CTRL_RW_MASK};
        ipp_pkg::OFF_STATUS:   s_next.rdata = {29'h0000_0000, s_reg.size_err, s_reg.format_error_flag, s_reg.out_end};
        ipp_pkg::OFF_FORMAT:   s_next.rdata = {11'h000, s_reg.out_fmt, 17'h0_0000, s_reg.in_fmt};
        ipp_pkg::OFF_Y_ADDR:   s_next.rdata = s_reg.y_addr;
        ipp_pkg::OFF_U_ADDR:   s_next.rdata = s_reg.u_addr;
        ipp_pkg::OFF_V_ADDR:   s_next.rdata = s_reg.v_addr;
        ipp_pkg::OFF_D_ADDR:   s_next.rdata = s_reg.d_addr;
        ipp_pkg::OFF_IN_SIZE:  s_next.rdata = {4'h0, s_reg.in_h, 4'h0, s_reg.in_w};
        ipp_pkg::OFF_OUT_SIZE: s_next.rdata = {4'h0, s_reg.out_h, 4'h0, s_reg.out_w};
        default:               s_next.rdata = 32'h0000_0000;
      endcase
    end

    if (reg_bus.sel && reg_bus.wr) begin
      unique case (reg_bus.addr)
        ipp_pkg::OFF_CONTROL: begin
          s_next.ctrl = (wctl & ipp_pkg::CTRL_RW_MASK & ~18'(1 << ipp_pkg::CB_RUN)) |
                        (s_reg.ctrl & 18'(1 << ipp_pkg::CB_RUN));
          if (wctl[ipp_pkg::CB_FIELD_LOAD]) begin
            s_next.field = wctl[ipp_pkg::CB_FIELD_SEL];
          end else begin
            s_next.ctrl[ipp_pkg::CB_FIELD_SEL] = s_reg.ctrl[ipp_pkg::CB_FIELD_SEL];
          end
          start = wctl[ipp_pkg::CB_RUN] && wctl[ipp_pkg::CB_ENABLE] && s_reg.phase == IPP_IDLE;
        end
        ipp_pkg::OFF_STATUS: begin
          if (!reg_bus.wdata[ipp_pkg::SB_OUT_END]) begin
            s_next.out_end = 1'b0;
          end
        end
        ipp_pkg::OFF_FORMAT: begin
          s_next.in_fmt  = reg_bus.wdata[ipp_pkg::FB_IN_FMT +: 2];
          s_next.out_fmt = reg_bus.wdata[ipp_pkg::FB_OUT_FMT +: 2];
        end
        ipp_pkg::OFF_Y_ADDR:   s_next.y_addr = reg_bus.wdata;
        ipp_pkg::OFF_U_ADDR:   s_next.u_addr = reg_bus.wdata;
        ipp_pkg::OFF_V_ADDR:   s_next.v_addr = reg_bus.wdata;
        ipp_pkg::OFF_D_ADDR:   s_next.d_addr = reg_bus.wdata;
        ipp_pkg::OFF_IN_SIZE: begin
          s_next.in_w = reg_bus.wdata[ipp_pkg::SZ_W_LSB +: ipp_pkg::DIM_W];
          s_next.in_h = reg_bus.wdata[ipp_pkg::SZ_H_LSB +: ipp_pkg::DIM_W];
        end
        ipp_pkg::OFF_OUT_SIZE: begin
          s_next.out_w = reg_bus.wdata[ipp_pkg::SZ_W_LSB +: ipp_pkg::DIM_W];
          s_next.out_h = reg_bus.wdata[ipp_pkg::SZ_H_LSB +: ipp_pkg::DIM_W];
        end
        default: ;
      endcase
    end

    if (start) begin
      s_next.size_err = s_reg.in_w < ipp_pkg::MIN_DIM || s_reg.in_h < ipp_pkg::MIN_DIM ||
                        s_reg.out_w == 12'h000 || s_reg.out_h == 12'h000 ||
                        (wctl[ipp_pkg::CB_VRSZ] && s_reg.out_w > ipp_pkg::MAX_OUT_W_VRSZ);
      // Packed YUV output cannot follow a conversion to RGB.
      s_next.format_error_flag  = wctl[ipp_pkg::CB_CSC] && s_reg.out_fmt == ipp_pkg::OUT_YUV422;
      if (!s_next.size_err && !s_next.format_error_flag) begin
        s_next.ctrl[ipp_pkg::CB_RUN] = 1'b1;
        s_next.out_end = 1'b0;
        s_next.phase   = IPP_NEXT;
        s_next.col     = 12'h000;
        s_next.row     = 12'h000;
        s_next.hpos    = '0;
        s_next.vpos    = '0;
        s_next.last    = 1'b0;
        s_next.wptr    = s_reg.d_addr;
      end
    end

    unique case (s_reg.phase)
      IPP_IDLE: ;
      IPP_NEXT: begin
        if (s_reg.last) begin
          done = 1'b1;
        // rows of the other field are skipped
        end else if (s_reg.ctrl[ipp_pkg::CB_FIELD_MODE] && s_reg.row[0] != s_reg.field) begin
          s_next.row  = s_reg.row + 12'h001;
          s_next.last = s_reg.row == s_reg.out_h - 12'h001;
          s_next.vpos = s_reg.vpos + ipp_pkg::POS_W'(ipp_step(vlut[s_reg.vpos[4:0]],
                        s_reg.ctrl[ipp_pkg::CB_VRSZ], s_reg.ctrl[ipp_pkg::CB_V_UP]));
        end else begin
          s_next.phase = IPP_RD_Y;
        end
      end
      IPP_RD_Y, IPP_RD_U, IPP_RD_V: begin
        // word reads from the source buffers
        if (!s_reg.rd.req) begin
          s_next.rd.req      = 1'b1;
          s_next.rd.page_map = s_reg.ctrl[ipp_pkg::CB_SRC_PMAP];
          if (s_reg.ctrl[ipp_pkg::CB_PACKED]) begin
            s_next.rd.addr = s_reg.y_addr + packed_off;
          end else if (s_reg.phase == IPP_RD_Y) begin
            s_next.rd.addr = s_reg.y_addr + 32'({12'h000, sy} * {12'h000, s_reg.in_w}) + 32'(sx);
          end else if (s_reg.phase == IPP_RD_U) begin
            s_next.rd.addr = s_reg.u_addr + ipp_chroma_off(s_reg.in_fmt, sx, sy, s_reg.in_w);
          end else begin
            s_next.rd.addr = s_reg.v_addr + ipp_chroma_off(s_reg.in_fmt, sx, sy, s_reg.in_w);
          end
        end else if (mem_rd_ack) begin
          s_next.rd.req = 1'b0;
          if (s_reg.ctrl[ipp_pkg::CB_PACKED]) begin
            // Packed word layout is Y0 U Y1 V from the low byte up.
            s_next.yb    = ipp_lane(mem_rd_data, {sx[0], 1'b0});
            s_next.ub    = ipp_lane(mem_rd_data, 2'h1);
            s_next.vb    = ipp_lane(mem_rd_data, 2'h3);
            s_next.phase = IPP_EMIT;
          end else if (s_reg.phase == IPP_RD_Y) begin
            s_next.yb    = ipp_lane(mem_rd_data, s_reg.rd.addr[1:0]);
            s_next.phase = IPP_RD_U;
          end else if (s_reg.phase == IPP_RD_U) begin
            s_next.ub    = ipp_lane(mem_rd_data, s_reg.rd.addr[1:0]);
            s_next.phase = IPP_RD_V;
          end else begin
            s_next.vb    = ipp_lane(mem_rd_data, s_reg.rd.addr[1:0]);
            s_next.phase = IPP_EMIT;
          end
        end
      end
      IPP_EMIT: begin
        if (s_reg.ctrl[ipp_pkg::CB_TO_DISP]) begin
          // direct path to the display FIFO
          s_next.disp.valid = 1'b1;
          s_next.disp.data  = pix_word;
        end else begin
          s_next.wr.req      = 1'b1;
          s_next.wr.addr     = s_reg.wptr;
          s_next.wr.data     = pix_word;
          s_next.wr.page_map = s_reg.ctrl[ipp_pkg::CB_DST_PMAP];
        end
        s_next.phase = IPP_WAIT_OUT;
      end
      IPP_WAIT_OUT: begin
        if ((s_reg.disp.valid && disp_ready) || (s_reg.wr.req && mem_wr_ack)) begin
          s_next.disp.valid = 1'b0;
          s_next.wr.req     = 1'b0;
          if (!s_reg.ctrl[ipp_pkg::CB_FIXED_DST]) begin
            s_next.wptr = s_reg.wptr + 32'h0000_0004;
          end
          s_next.phase = IPP_NEXT;
          if (s_reg.col == s_reg.out_w - 12'h001) begin
            s_next.col  = 12'h000;
            s_next.hpos = '0;
            s_next.row  = s_reg.row + 12'h001;
            s_next.last = s_reg.row == s_reg.out_h - 12'h001;
            s_next.vpos = s_reg.vpos + ipp_pkg::POS_W'(ipp_step(vlut[s_reg.vpos[4:0]],
                          s_reg.ctrl[ipp_pkg::CB_VRSZ], s_reg.ctrl[ipp_pkg::CB_V_UP]));
          end else begin
            s_next.col  = s_reg.col + 12'h001;
            s_next.hpos = s_reg.hpos + ipp_pkg::POS_W'(ipp_step(hlut[s_reg.hpos[4:0]],
                          s_reg.ctrl[ipp_pkg::CB_HRSZ], s_reg.ctrl[ipp_pkg::CB_H_UP]));
          end
        end
      end
      IPP_HOLD: begin
        // first claimant after a display frame
        if (rd_status) begin
          s_next.phase = IPP_IDLE;
        end else if (disp_req) begin
          s_next.out_end = 1'b0;
          s_next.phase   = IPP_NEXT;
          s_next.col     = 12'h000;
          s_next.row     = 12'h000;
          s_next.hpos    = '0;
          s_next.vpos    = '0;
          s_next.last    = 1'b0;
        end
      end
    endcase

    if (done) begin
      // A completion set beats a status clear in the same cycle.
      s_next.out_end = 1'b1;
      s_next.ctrl[ipp_pkg::CB_RUN] = 1'b0;
      if (s_reg.ctrl[ipp_pkg::CB_FIELD_MODE]) begin
        s_next.field = ~s_reg.field;
      end
      s_next.phase = s_reg.ctrl[ipp_pkg::CB_TO_DISP] ? IPP_HOLD : IPP_IDLE;
    end

    // soft reset keeps the read data and takes only the enable bit from the written word
    if (wr_ctrl && wctl[ipp_pkg::CB_SRST]) begin
      s_next = STATE_RESET;
      s_next.ctrl[ipp_pkg::CB_ENABLE] = wctl[ipp_pkg::CB_ENABLE];
      s_next.rdata = s_reg.rdata;
    end

    // active-low request while done is flagged and allowed
    s_next.irq_n = ~(s_next.out_end && s_next.ctrl[ipp_pkg::CB_IRQ_EN]);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign mem_rd    = s_reg.rd;
  assign mem_wr    = s_reg.wr;
  assign disp_out  = s_reg.disp;
  assign irq_n     = s_reg.irq_n;

endmodule
`default_nettype wire

// ===== tb/ipp_unit_sva.sv
// Port-level assertions for the post-processing unit.
`timescale 1ns/100ps
`default_nettype none
module ipp_unit_sva (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire ipp_pkg::ipp_bus_t  reg_bus,
  input wire logic [31:0]        reg_rdata,
  input wire ipp_pkg::ipp_rd_t   mem_rd,
  input wire logic               mem_rd_ack,
  input wire ipp_pkg::ipp_wr_t   mem_wr,
  input wire logic               mem_wr_ack,
  input wire logic               irq_n
);
  logic        wc;
  logic        kill;
  logic [17:0] c_reg;
  assign wc = reg_bus.sel && reg_bus.wr && reg_bus.addr == 8'h00;
  assign kill = (reg_bus.sel && reg_bus.wr && reg_bus.addr == 8'h04 && !reg_bus.wdata[0])
                || (wc && (reg_bus.wdata[6] || !reg_bus.wdata[5]));
  // Shadow of control; a soft reset leaves only the written enable bit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) c_reg <= 18'h0_0000;
    else if (wc) c_reg <= reg_bus.wdata[6] ? {17'h0_0000, reg_bus.wdata[0]} : reg_bus.wdata[17:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ctrl; reg_bus.sel && reg_bus.rd && reg_bus.addr == 8'h00 |=> reg_rdata[31:17] == {14'h0, c_reg[17]}
    && !reg_rdata[15] && reg_rdata[14:2] == {c_reg[14:8], 2'h0, c_reg[5:2]} && reg_rdata[0] == c_reg[0]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read");
  property p_off; wc && !reg_bus.wdata[0] |=> ##1 !mem_rd.req [*8]; endproperty
  a_off: assert property (p_off) else $error("read while disabled");
  property p_srst; wc && reg_bus.wdata[6] |-> ##2 !mem_rd.req && !mem_wr.req; endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  property p_rdh; mem_rd.req && !mem_rd_ack |=> mem_rd.req && $stable(mem_rd.addr); endproperty
  a_rdh: assert property (p_rdh) else $error("read hold");
  property p_wrh; mem_wr.req && !mem_wr_ack |=> mem_wr.req && $stable(mem_wr.addr) && $stable(mem_wr.data); endproperty
  a_wrh: assert property (p_wrh) else $error("write hold");
  property p_dst; mem_wr.req |-> !c_reg[11] && mem_wr.page_map == c_reg[13]; endproperty
  a_dst: assert property (p_dst) else $error("write target");
  property p_src; mem_rd.req |-> mem_rd.page_map == c_reg[12]; endproperty
  a_src: assert property (p_src) else $error("source map");
  property p_ien; $fell(irq_n) |-> c_reg[5]; endproperty
  a_ien: assert property (p_ien) else $error("irq disabled");
  property p_ihold; !irq_n && !kill && !$past(kill) |=> !irq_n; endproperty
  a_ihold: assert property (p_ihold) else $error("irq hold");
endmodule
bind ipp_unit ipp_unit_sva chk (.sys_clk, .rst_n, .reg_bus, .reg_rdata, .mem_rd, .mem_rd_ack, .mem_wr,
  .mem_wr_ack, .irq_n);
`default_nettype wire

// ===== tb/ipp_far_end.sv
// Memory and display sink model on the far side of the unit.
`timescale 1ns/100ps
`default_nettype none
module ipp_far_end (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               slow,
  input  wire ipp_pkg::ipp_rd_t   mem_rd,
  input  wire ipp_pkg::ipp_wr_t   mem_wr,
  input  wire ipp_pkg::ipp_disp_t disp_out,
  output logic                    mem_rd_ack,
  output logic [31:0]             mem_rd_data,
  output logic                    mem_wr_ack,
  output logic                    disp_ready
);
  logic [1:0] wait_reg;
  logic       hit;
  // Slow mode stalls each transfer three cycles so that hold behaviour is exercised.
  assign hit = wait_reg == (slow ? 2'h3 : 2'h0);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wait_reg <= 2'h0;
    else if ((mem_rd.req || mem_wr.req || disp_out.valid) && !hit) wait_reg <= wait_reg + 2'h1;
    else wait_reg <= 2'h0;
  end
  // read words answered after the wait; idle data shows the inverse.
  assign mem_rd_ack = mem_rd.req && hit;
  assign mem_rd_data = mem_rd_ack ? {4{mem_rd.addr[9:2]}} : ~{4{mem_rd.addr[9:2]}};
  // writes and display words taken under the same stall.
  assign mem_wr_ack = mem_wr.req && hit;
  assign disp_ready = disp_out.valid && hit;
endmodule
`default_nettype wire

// ===== tb/image_post_process_control_bench.sv
// Self-checking bench for the post-processing unit.
`timescale 1ns/100ps
`default_nettype none
module image_post_process_control_bench;
  logic               sys_clk = 0, rst_n = 0, slow = 0, disp_req = 0;
  logic               mem_rd_ack, mem_wr_ack, disp_ready, irq_n;
  logic [31:0]        reg_rdata, mem_rd_data, ea, stp;
  ipp_pkg::ipp_bus_t  reg_bus = '0;
  ipp_pkg::ipp_rd_t   mem_rd;
  ipp_pkg::ipp_wr_t   mem_wr;
  ipp_pkg::ipp_disp_t disp_out;
  int                 n_fail = 0, num_checks = 0, nw = 0, cyc = 0;
  logic               pk = 1;
  logic [7:0]         eb = 8'h80;
  ipp_unit uut (.sys_clk, .rst_n, .reg_bus, .reg_rdata, .mem_rd, .mem_rd_ack, .mem_rd_data, .mem_wr,
    .mem_wr_ack, .disp_out, .disp_ready, .disp_req, .irq_n);
  ipp_far_end far (.sys_clk, .rst_n, .slow, .mem_rd, .mem_wr, .disp_out, .mem_rd_ack, .mem_rd_data,
    .mem_wr_ack, .disp_ready);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Packed frames carry the source row byte in both lanes; the planar frame converts Y 0x80, U and V 0 to RGB565.
  function automatic logic [31:0] px;
    return pk ? {16'h0000, {2{eb + 8'(nw / 2)}}} : 32'h0000_07e0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 reg_bus = '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    #1 reg_bus.sel = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    #1 reg_bus = '{1'b1, 1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    #1 reg_bus.sel = 0;
    @(posedge sys_clk);
    #1 chk(n, e, reg_rdata);
  endtask
  // A zero control word means a display request pulse instead of a run write.
  task automatic frame(input logic [31:0] c, a, s, n, input logic ie);
    nw = 0;
    ea = a;
    stp = s;
    if (c != 0) wr(8'h00, c);
    else begin
      @(posedge sys_clk);
      #1 disp_req = 1;
      @(posedge sys_clk);
      #1 disp_req = 0;
    end
    for (int i = 0; i < 400 && nw < n; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    #1 chk("pixels", n, nw);
    chk("irq_n", !ie, irq_n);
  endtask
  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (mem_wr.req && mem_wr_ack) begin
      chk("wr_addr", ea, mem_wr.addr);
      chk("wr_data", px(), mem_wr.data);
      ea += stp;
      nw++;
    end
    if (disp_out.valid && disp_ready) begin
      chk("disp_data", px(), disp_out.data);
      nw++;
    end
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h04, 32'h1, "status");
    rd(8'hfc, 32'h0, "unmapped");
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h1, "ctrl");
    wr(8'h00, 32'hffff_ffbf);
    rd(8'h00, 32'h0003_7f3d, "ctrl");
    rd(8'h04, 32'h5, "status");
    wr(8'h00, 32'h40);
    wr(8'h00, 32'h2);
    rd(8'h00, 32'h0, "ctrl");
    wr(8'h08, 32'h0018_0001);
    wr(8'h0c, 32'h200);
    wr(8'h18, 32'h100);
    wr(8'h1c, 32'h0002_0002);
    wr(8'h20, 32'h0002_0002);
    wr(8'h04, 32'h0);
    frame(32'h3423, 32'h100, 32'h4, 4, 1);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq_clr", 1, irq_n);
    slow = 1;
    frame(32'h0002_0403, 32'h100, 32'h0, 4, 0);
    wr(8'h04, 32'h0);
    eb = 8'h81;
    frame(32'h0001_c403, 32'h100, 32'h4, 2, 0);
    eb = 8'h80;
    frame(32'h4403, 32'h100, 32'h4, 2, 0);
    wr(8'h08, 32'h0008_0002);
    pk = 0;
    frame(32'h13, 32'h100, 32'h4, 4, 0);
    pk = 1;
    wr(8'h08, 32'h0018_0001);
    frame(32'hc03, 32'h0, 32'h0, 4, 0);
    frame(32'h0, 32'h0, 32'h0, 4, 0);
    rd(8'h04, 32'h1, "status");
    frame(32'h0, 32'h0, 32'h0, 0, 0);
    results();
  end
endmodule
`default_nettype wire
